// ==== rtl/dbu_map.svh ====
`ifndef DBU_MAP_SVH
`define DBU_MAP_SVH

// Debug register numbers on the move-debug port
`define DBU_REG_ADDR0 3'h0
`define DBU_REG_ADDR1 3'h1
`define DBU_REG_ADDR2 3'h2
`define DBU_REG_ADDR3 3'h3
`define DBU_REG_RSVD4 3'h4
`define DBU_REG_RSVD5 3'h5
`define DBU_REG_STATUS 3'h6
`define DBU_REG_CONTROL 3'h7

// Control register field positions
`define DBU_CTL_LEXACT_BIT 8
`define DBU_CTL_GEXACT_BIT 9
`define DBU_CTL_GUARD_BIT 13
`define DBU_CTL_TYPE_LSB 16
// Status register field positions
`define DBU_STS_ACCESS_BIT 13
`define DBU_STS_STEP_BIT 14
`define DBU_STS_TASK_BIT 15

// Reset values
`define DBU_CONTROL_RESET 32'h0000_0400
`define DBU_STATUS_RESET 32'hFFFF_0FF0
`define DBU_ADDR_RESET 32'h0000_0000

// Writable masks
`define DBU_CONTROL_WMASK 32'hFFFF_23FF
`define DBU_STATUS_WMASK 32'h0000_E00F

// Exception vectors
`define DBU_VEC_DEBUG 8'h01
`define DBU_VEC_BREAK 8'h03

`endif

// ==== rtl/dbu_pkg.sv ====
package dbu_pkg;
  // Breakpoint kind field
  typedef enum logic [1:0] {
    DBU_TYPE_EXEC = 2'h0,
    DBU_TYPE_WRITE = 2'h1,
    DBU_TYPE_IO = 2'h2,
    DBU_TYPE_RDWR = 2'h3
  } dbu_bp_type_type;
  // Breakpoint length field
  typedef enum logic [1:0] {
    DBU_LEN_1 = 2'h0,
    DBU_LEN_2 = 2'h1,
    DBU_LEN_UNDEF = 2'h2,
    DBU_LEN_4 = 2'h3
  } dbu_bp_len_type;
  // Kind of processor cycle presented for comparison
  typedef enum logic [1:0] {
    DBU_CYC_FETCH = 2'h0,
    DBU_CYC_WRITE = 2'h1,
    DBU_CYC_IO = 2'h2,
    DBU_CYC_READ = 2'h3
  } dbu_cycle_type;
endpackage

// ==== rtl/dbu_comparator.sv ====
`timescale 1ns/1ns
`default_nettype none

// One breakpoint address comparator
module dbu_comparator (
  input wire logic [31:0] bp_addr,
  input wire logic [1:0] bp_type,
  input wire logic [1:0] bp_len,
  input wire logic debug_extensions_control,
  input wire logic cyc_valid,
  input wire logic [1:0] cyc_kind,
  input wire logic [31:0] cyc_addr,
  output logic hit
);
  logic [31:0] addr_mask;
  logic addr_eq;
  logic kind_ok;

  ////////////////////////////////////////////////////////////////////////
  // Address match with low bits ignored for wide lengths
  always_comb begin
    unique case (dbu_pkg::dbu_bp_len_type'(bp_len))
      dbu_pkg::DBU_LEN_2: addr_mask = 32'hFFFF_FFFE;
      dbu_pkg::DBU_LEN_4: addr_mask = 32'hFFFF_FFFC;
      default: addr_mask = 32'hFFFF_FFFF; // One byte; 10b treated alike
    endcase
    addr_eq = ((bp_addr ^ cyc_addr) & addr_mask) == 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Cycle kind selection by breakpoint type
  always_comb begin
    unique case (dbu_pkg::dbu_bp_type_type'(bp_type))
      dbu_pkg::DBU_TYPE_EXEC:
        kind_ok = cyc_kind == dbu_pkg::DBU_CYC_FETCH;
      dbu_pkg::DBU_TYPE_WRITE:
        kind_ok = cyc_kind == dbu_pkg::DBU_CYC_WRITE;
      dbu_pkg::DBU_TYPE_IO:
        // Undefined without extensions: never matches
        kind_ok = debug_extensions_control &&
          cyc_kind == dbu_pkg::DBU_CYC_IO;
      default:
        kind_ok = cyc_kind == dbu_pkg::DBU_CYC_WRITE ||
          cyc_kind == dbu_pkg::DBU_CYC_READ;
    endcase
    hit = cyc_valid && kind_ok && addr_eq;
  end
endmodule

`default_nettype wire

// ==== rtl/dbu_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbu_map.svh"

// Behaviour
// - Four 32-bit breakpoint addresses compared to cycles
// - Without extensions, regs 5/4 alias 7/6
// - With extensions, regs 5/4 raise undefined opcode
// - Enabled breakpoint hit sets its match flag
// - Disabled hits flag too but never except
// - Guard set: debug-register access flags and faults
// - Trap flag: step exception after each instruction
// - Task trap bit: set task flag, except
// - Local enables cleared on task switch
// - Global enables survive task switch, override local
// - Legacy exact bits stored, no effect
// - Guard bit cleared on any debug exception
// - Type field: exec, write, I/O, read/write
// - Length field: one, two, four bytes
// - Data, I/O, step, task events are traps
// - Exec breakpoints, register access are faults
// - Opcode CCh raises vector 03h trap
module dbu_unit (
  input wire logic mclk,
  input wire logic reset_n,
  // Extension control bit 3 from the core
  input wire logic debug_extensions_control,
  // Move-debug-register port, decoded instruction
  input wire logic dreg_rd,
  input wire logic dreg_wr,
  input wire logic [2:0] dreg_num,
  input wire logic [31:0] dreg_wdata,
  output logic [31:0] dreg_rdata,
  // Processor cycle presented for comparison
  input wire logic cyc_valid,
  input wire logic [1:0] cyc_kind,
  input wire logic [31:0] cyc_addr,
  // Instruction retirement and events
  input wire logic instr_done,
  input wire logic trap_flag,
  input wire logic task_switch,
  input wire logic task_trap_bit,
  input wire logic int3_done,
  // Exception request to the pipeline
  output logic exc_valid,
  output logic exc_fault,
  output logic [7:0] exc_vector,
  output logic exc_undef_opcode
);
  // Architectural registers
  logic [31:0] addr_reg [4];
  logic [31:0] addr_next [4];
  logic [31:0] control_reg;
  logic [31:0] control_next;
  logic [31:0] status_reg;
  logic [31:0] status_next;
  // Data-kind hits collected until the instruction retires
  logic [3:0] pend_hit_reg;
  logic [3:0] pend_hit_next;
  // Exception output registers
  logic exc_valid_reg;
  logic exc_valid_next;
  logic exc_fault_reg;
  logic exc_fault_next;
  logic [7:0] exc_vector_reg;
  logic [7:0] exc_vector_next;
  logic undef_reg;
  logic undef_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // Comparator results and enables
  logic [3:0] hit;
  logic [3:0] enabled;
  logic [2:0] eff_num;
  logic reserved_hit;
  logic access;

  ////////////////////////////////////////////////////////////////////////
  // Four comparators
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      dbu_comparator u_cmp (
        .bp_addr(addr_reg[gi]),
        .bp_type(control_reg[`DBU_CTL_TYPE_LSB + 4*gi +: 2]),
        .bp_len(control_reg[`DBU_CTL_TYPE_LSB + 4*gi + 2 +: 2]),
        .debug_extensions_control(debug_extensions_control),
        .cyc_valid(cyc_valid),
        .cyc_kind(cyc_kind),
        .cyc_addr(cyc_addr),
        .hit(hit[gi])
      );
      // Global enable overrides a clear local enable
      assign enabled[gi] = control_reg[2*gi] | control_reg[2*gi+1];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Register number decode and aliasing
  always_comb begin
    eff_num = dreg_num;
    reserved_hit = dreg_num == `DBU_REG_RSVD4 || dreg_num == `DBU_REG_RSVD5;
    if (reserved_hit && !debug_extensions_control) begin
      // Reserved numbers alias control and status
      eff_num = (dreg_num == `DBU_REG_RSVD5) ?
        `DBU_REG_CONTROL : `DBU_REG_STATUS;
    end
    access = dreg_rd | dreg_wr;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state for registers and exceptions
  always_comb begin
    logic guard_trip;
    logic undef_trip;
    logic fetch_fault;
    logic [3:0] fetch_hit;
    logic [3:0] data_hit;
    logic trap_evt;
    guard_trip = 1'b0;
    undef_trip = 1'b0;
    fetch_fault = 1'b0;
    fetch_hit = 4'h0;
    data_hit = 4'h0;
    trap_evt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      addr_next[i] = addr_reg[i];
    end
    control_next = control_reg;
    status_next = status_reg;
    pend_hit_next = pend_hit_reg;
    exc_valid_next = 1'b0;
    exc_fault_next = 1'b0;
    exc_vector_next = exc_vector_reg;
    undef_next = 1'b0;
    rdata_next = rdata_reg;

    // Split hits by kind of cycle
    if (cyc_kind == dbu_pkg::DBU_CYC_FETCH) begin
      fetch_hit = hit;
    end else begin
      data_hit = hit;
    end

    if (access && control_reg[`DBU_CTL_GUARD_BIT]) begin
      // Guarded access: fault before the access
      guard_trip = 1'b1;
    end else if (access && reserved_hit && debug_extensions_control) begin
      undef_trip = 1'b1;
    end

    // Match flags set for every satisfied breakpoint
    status_next[3:0] = status_reg[3:0] | hit;
    fetch_fault = |(fetch_hit & enabled);
    pend_hit_next = pend_hit_reg | (data_hit & enabled);

    // Register write, only when not refused
    if (dreg_wr && !guard_trip && !undef_trip) begin
      unique case (eff_num)
        `DBU_REG_CONTROL:
          control_next = (dreg_wdata & `DBU_CONTROL_WMASK) |
            `DBU_CONTROL_RESET;
        `DBU_REG_STATUS:
          status_next = (dreg_wdata & `DBU_STATUS_WMASK) |
            (`DBU_STATUS_RESET & ~`DBU_STATUS_WMASK) | {28'h0, hit};
        default:
          addr_next[eff_num[1:0]] = dreg_wdata;
      endcase
    end
    if (dreg_rd && !guard_trip && !undef_trip) begin
      unique case (eff_num)
        `DBU_REG_CONTROL: rdata_next = control_reg;
        `DBU_REG_STATUS: rdata_next = status_reg;
        default: rdata_next = addr_reg[eff_num[1:0]];
      endcase
    end

    // Exception priority: faults first, then traps
    if (guard_trip) begin
      status_next[`DBU_STS_ACCESS_BIT] = 1'b1;
      exc_valid_next = 1'b1;
      exc_fault_next = 1'b1;
      exc_vector_next = `DBU_VEC_DEBUG;
    end else if (undef_trip) begin
      undef_next = 1'b1;
    end else if (fetch_fault) begin
      exc_valid_next = 1'b1;
      exc_fault_next = 1'b1;
      exc_vector_next = `DBU_VEC_DEBUG;
    end else if (instr_done) begin
      // Traps taken after the instruction completes
      if (trap_flag) begin
        status_next[`DBU_STS_STEP_BIT] = 1'b1;
        trap_evt = 1'b1;
      end
      if (task_switch && task_trap_bit) begin
        status_next[`DBU_STS_TASK_BIT] = 1'b1;
        trap_evt = 1'b1;
      end
      if (|pend_hit_next) begin
        trap_evt = 1'b1;
      end
      pend_hit_next = 4'h0;
      if (trap_evt) begin
        exc_valid_next = 1'b1;
        exc_vector_next = `DBU_VEC_DEBUG;
      end else if (int3_done) begin
        exc_valid_next = 1'b1;
        exc_vector_next = `DBU_VEC_BREAK;
      end
    end

    // Task switch drops local enables only
    if (instr_done && task_switch) begin
      for (int i = 0; i < 4; i++) begin
        control_next[2*i] = 1'b0;
      end
    end
    // Guard drops whenever a debug exception is raised
    if (exc_valid_next && exc_vector_next == `DBU_VEC_DEBUG) begin
      control_next[`DBU_CTL_GUARD_BIT] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        addr_reg[i] <= `DBU_ADDR_RESET;
      end
      control_reg <= `DBU_CONTROL_RESET;
      status_reg <= `DBU_STATUS_RESET;
      pend_hit_reg <= 4'h0;
      exc_valid_reg <= 1'b0;
      exc_fault_reg <= 1'b0;
      exc_vector_reg <= 8'h00;
      undef_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        addr_reg[i] <= addr_next[i];
      end
      control_reg <= control_next;
      status_reg <= status_next;
      pend_hit_reg <= pend_hit_next;
      exc_valid_reg <= exc_valid_next;
      exc_fault_reg <= exc_fault_next;
      exc_vector_reg <= exc_vector_next;
      undef_reg <= undef_next;
      rdata_reg <= rdata_next;
    end
  end

  // Registered outputs
  assign dreg_rdata = rdata_reg;
  assign exc_valid = exc_valid_reg;
  assign exc_fault = exc_fault_reg;
  assign exc_vector = exc_vector_reg;
  assign exc_undef_opcode = undef_reg;
endmodule

`default_nettype wire

// ==== dv/dbu_unit_props.sv ====
`timescale 1ns/1ns
`default_nettype none

// Port checker for the debug unit
module dbu_unit_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic debug_extensions_control,
  input wire logic dreg_rd,
  input wire logic dreg_wr,
  input wire logic [2:0] dreg_num,
  input wire logic [31:0] dreg_rdata,
  input wire logic cyc_valid,
  input wire logic instr_done,
  input wire logic trap_flag,
  input wire logic task_switch,
  input wire logic task_trap_bit,
  input wire logic int3_done,
  input wire logic exc_valid,
  input wire logic exc_fault,
  input wire logic [7:0] exc_vector,
  input wire logic exc_undef_opcode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Any access or cycle taken this edge
  logic busy;
  assign busy = dreg_rd | dreg_wr | cyc_valid;
  // Access to a reserved number
  logic rsvd;
  assign rsvd = (dreg_rd | dreg_wr) & (dreg_num[2:1] == 2'h2);
  ////////////////////////////////////////////////////////////////////////////
  property p_undef;
    exc_undef_opcode |-> $past(rsvd && debug_extensions_control);
  endproperty
  a_undef: assert property (p_undef) else $error("stray undef");
  property p_alias;
    (dreg_rd || dreg_wr) && !debug_extensions_control |=> !exc_undef_opcode;
  endproperty
  a_alias: assert property (p_alias) else $error("undef on alias");
  property p_fault;
    exc_valid && exc_fault |-> exc_vector == 8'h01 && $past(busy);
  endproperty
  a_fault: assert property (p_fault) else $error("bad fault");
  property p_trap;
    exc_valid && !exc_fault |-> $past(instr_done);
  endproperty
  // Trap only ever follows a retirement
  a_trap: assert property (p_trap) else $error("trap not at retire");
  property p_step;
    instr_done && trap_flag && !busy |=>
      exc_valid && !exc_fault && exc_vector == 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("no step trap");
  property p_task;
    instr_done && task_switch && task_trap_bit && !busy |=>
      exc_valid ##0 exc_vector == 8'h01;
  endproperty
  a_task: assert property (p_task) else $error("no task trap");
  property p_brk;
    exc_valid && exc_vector == 8'h03 |-> !exc_fault && $past(int3_done);
  endproperty
  a_brk: assert property (p_brk) else $error("bad break trap");
  property p_hold;
    !dreg_rd |=> $stable(dreg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_fault: cover property (exc_valid && exc_fault);
  c_brk: cover property (exc_valid && exc_vector == 8'h03);
  c_undef: cover property (exc_undef_opcode);
endmodule

bind dbu_unit dbu_unit_props u_dbu_unit_props (.*);
`default_nettype wire

// ==== dv/dbu_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// Core pipeline model: presents a cycle, then retires
module dbu_core_model (
  input wire logic mclk,
  output logic cyc_valid,
  output logic [1:0] cyc_kind,
  output logic [31:0] cyc_addr,
  output logic instr_done,
  output logic trap_flag,
  output logic task_switch,
  output logic task_trap_bit,
  output logic int3_done
);
  initial begin
    {cyc_valid, instr_done, trap_flag, cyc_kind} = 5'h00;
    {task_switch, task_trap_bit, int3_done} = 3'h0;
    cyc_addr = 32'h0000_0000;
  end
  // Flags f: step, task switch, task trap bit, break opcode
  task automatic run(input logic [1:0] k, input logic [31:0] a,
      input logic [3:0] f, input int gap);
    @(posedge mclk);
    cyc_valid <= 1'b1;
    cyc_kind <= k;
    cyc_addr <= a;
    @(posedge mclk);
    cyc_valid <= 1'b0;
    cyc_addr <= ~a; // Idle bus shows no stale address
    repeat (gap) @(posedge mclk);
    // Retire after the cycle
    {trap_flag, task_switch, task_trap_bit, int3_done} <= f;
    instr_done <= 1'b1;
    @(posedge mclk);
    instr_done <= 1'b0;
    {trap_flag, task_switch, task_trap_bit, int3_done} <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ==== dv/dbu_unit_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbu_map.svh"

// Bench with a register and event model
module dbu_unit_tb;
  logic mclk, reset_n, debug_extensions_control, dreg_rd, dreg_wr;
  logic [2:0] dreg_num;
  logic [31:0] dreg_wdata, dreg_rdata, cyc_addr, m_ctl, m_sts, r;
  logic cyc_valid, instr_done, trap_flag, task_switch, task_trap_bit;
  logic int3_done, exc_valid, exc_fault, exc_undef_opcode;
  logic [1:0] cyc_kind;
  logic [7:0] exc_vector;
  logic [31:0] m_adr [4];
  logic [8:0] seen [$];
  logic [8:0] want [$];
  int num_errors, comparisons, cycles;
  dbu_unit u_dbu_unit (.*);
  dbu_core_model u_dbu_core_model (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Exception log and hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (exc_valid === 1'b1) seen.push_back({exc_fault, exc_vector});
    if (exc_undef_opcode === 1'b1) seen.push_back(9'h1ff);
    if (cycles == 4000) begin
      num_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task cq();
    repeat (3) @(posedge mclk);
    chk(32'(seen.size()), 32'(want.size()));
    foreach (want[i]) chk(32'(seen[i]), 32'(want[i]));
    seen.delete();
    want.delete();
  endtask
  // Register move and its modelled outcome
  task ra(input logic w, input logic [2:0] n, input logic [31:0] d);
    logic [2:0] m;
    m = (n[2:1] == 2'h2) ? n + 3'h2 : n;
    @(posedge mclk);
    dreg_rd <= !w;
    dreg_wr <= w;
    dreg_num <= n;
    dreg_wdata <= w ? d : $urandom(); // Reads carry noise on the data
    @(posedge mclk);
    dreg_rd <= 1'b0;
    dreg_wr <= 1'b0;
    #1;
    if (m_ctl[13]) begin
      want.push_back(9'h101);
      m_sts[13] = 1'b1;
      m_ctl[13] = 1'b0;
    end else if (m != n && debug_extensions_control) begin
      want.push_back(9'h1ff);
    end else if (w) begin
      if (m < 4) m_adr[m[1:0]] = d;
      else if (m == 6) m_sts = m_sts & ~`DBU_STATUS_WMASK
        | d & `DBU_STATUS_WMASK;
      else m_ctl = d & `DBU_CONTROL_WMASK | 32'h0000_0400;
    end else begin
      r = m < 4 ? m_adr[m[1:0]] : m == 6 ? m_sts : m_ctl;
      chk(dreg_rdata, r);
    end
  endtask
  // One instruction with a cycle; hits from the model
  task op(input logic [1:0] k, input logic [31:0] a, input logic [3:0] f);
    logic [3:0] h, e;
    logic [1:0] t, l;
    logic [31:0] mk;
    for (int i = 0; i < 4; i++) begin
      t = m_ctl[16 + 4 * i +: 2];
      l = m_ctl[18 + 4 * i +: 2];
      mk = l == 2'h3 ? 32'hffff_fffc : l == 2'h1 ? 32'hffff_fffe : '1;
      h[i] = (a & mk) == (m_adr[i] & mk) && (t == 2'h0 ? k == 2'h0 :
        t == 2'h1 ? k == 2'h1 : t == 2'h3 ? k[0] :
        debug_extensions_control && k == 2'h2);
      e[i] = h[i] && (m_ctl[2 * i] || m_ctl[2 * i + 1]);
    end
    m_sts[3:0] = m_sts[3:0] | h;
    u_dbu_core_model.run(k, a, f, $urandom_range(2));
    if (e != 0 && k == 2'h0) begin
      want.push_back(9'h101);
      m_ctl[13] = 1'b0;
    end
    if ((e != 0 && k != 2'h0) || f[3] || f[2] && f[1]) begin
      want.push_back(9'h001);
      m_ctl[13] = 1'b0;
    end else if (f[0]) want.push_back(9'h003);
    m_sts[14] = m_sts[14] | f[3];
    m_sts[15] = m_sts[15] | f[2] & f[1];
    if (f[2]) m_ctl = m_ctl & 32'hffff_ffaa;
  endtask
  task test_done();
    $display("Counts: %0d errors, %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, debug_extensions_control, dreg_rd, dreg_wr} = 4'h0;
    dreg_num = 3'h0;
    dreg_wdata = 32'h0000_0000;
    m_ctl = `DBU_CONTROL_RESET;
    m_sts = `DBU_STATUS_RESET;
    m_adr = '{default: 32'h0000_0000};
    r = $urandom(32'h0000_cf9a);
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values, aliases, write back through the alias
    for (int n = 0; n < 8; n++) ra(1'b0, n[2:0], 32'h0);
    for (int n = 0; n < 4; n++) ra(1'b1, n[2:0], $urandom());
    ra(1'b1, 3'h5, 32'hffff_dfff);
    for (int n = 0; n < 8; n++) ra(1'b0, n[2:0], 32'h0);
    // Exec fault beside a disabled twin; write trap on four bytes
    ra(1'b1, 3'h0, 32'h0000_1000);
    ra(1'b1, 3'h1, 32'h0000_1000);
    ra(1'b1, 3'h2, 32'h0000_2000);
    ra(1'b1, 3'h7, 32'h0000_0001);
    op(2'h0, 32'h0000_1000, 4'h0);
    ra(1'b1, 3'h7, 32'h0d00_0020);
    op(2'h1, 32'h0000_2003, 4'h0);
    op(2'h3, 32'h0000_2003, 4'h0);
    // Every legal type and length on one global enable
    debug_extensions_control <= 1'b1;
    for (int t = 0; t < 16; t++) begin
      if (t[3:2] == 2'h2 || t[1:0] == 2'h0 && t[3:2] != 2'h0) continue;
      ra(1'b1, 3'h7, {12'h0, t[3:0], 16'h0002});
      for (int k = 0; k < 4; k++) op(k[1:0], 32'h1000 + ($urandom() & 7), 0);
    end
    ra(1'b0, 3'h4, 32'h0);
    ra(1'b1, 3'h5, 32'h0);
    cq();
    debug_extensions_control <= 1'b0;
    ra(1'b0, 3'h6, 32'h0);
    ra(1'b1, 3'h6, 32'h0);
    // Step, task traps, local clear, break opcode
    ra(1'b1, 3'h7, 32'h0000_0027);
    op(2'h3, 32'h0, 4'h8);
    op(2'h3, 32'h0, 4'h6);
    op(2'h3, 32'h0, 4'h4);
    op(2'h3, 32'h0, 4'h1);
    ra(1'b0, 3'h7, 32'h0);
    ra(1'b0, 3'h6, 32'h0);
    // Guarded access, guard cleared by a step trap too
    ra(1'b1, 3'h7, 32'h0000_2000);
    ra(1'b0, 3'h3, 32'h0);
    ra(1'b0, 3'h7, 32'h0);
    ra(1'b1, 3'h7, 32'h0000_2000);
    op(2'h3, 32'h0, 4'h8);
    ra(1'b0, 3'h7, 32'h0);
    ra(1'b0, 3'h6, 32'h0);
    cq();
    test_done();
  end
endmodule
`default_nettype wire
